/* File: fmsp_ctrl.sv */
// Flash controller: mode, address, data, signature and keyed page protection
`timescale 1ns/1ps
`default_nettype none
module fmsp_ctrl (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [31:0] bus_wdata_i,
	output logic [31:0] bus_rdata_o,
	output logic fl_req_o,
	output fmsp_pkg::fmsp_op_t fl_op_o,
	output logic [15:0] fl_addr_o,
	output logic [15:0] fl_wdata_o,
	input wire logic fl_ack_i,
	input wire logic [15:0] fl_rdata_i,
	input wire logic abort_i,
	input wire logic dbg_rd_req_i,
	output logic dbg_rd_grant_o,
	output logic irq_o
);
	// ====================================================
	// Registers and state
	fmsp_pkg::fmsp_state_t state;
	logic [15:0] mode;
	logic [15:0] target;
	logic [15:0] data_word;
	logic [31:0] live;
	logic [3:0] status;
	logic [7:0] cmd;
	logic [7:0] cur_cmd;
	logic [15:0] walk;
	logic [15:0] sig_limit;
	logic pend_prog;
	logic done_ok;
	logic done_fail;
	logic [31:0] persist;
	logic [31:0] nv_pro;
	logic [31:0] nv_key;
	fmsp_sig_if sig_bus ();

	// ====================================================
	// Decode
	logic wr_mode, wr_cmd, wr_data, wr_target, wr_persist, wr_live, rd_status;
	logic idle;
	logic [31:0] presented_key;
	logic key_open, key_ok, page_guarded, ew_en, abort_now, mass_ok, sig_empty;
	logic [15:0] sig_start, sig_end;

	assign idle = (state == fmsp_pkg::FMSP_ST_IDLE);
	assign wr_mode = bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_MODE;
	assign wr_cmd = bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_CMD && idle;
	assign wr_data = bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_DATA && idle;
	assign wr_target = bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_TARGET && idle;
	assign wr_persist = bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_PERSIST && key_ok;
	assign wr_live = bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_LIVE && key_ok;
	assign rd_status = bus_rd_i && bus_addr_i == fmsp_pkg::ADDR_STATUS;

	// Key straddles the two 16-bit registers: upper half in the target address
	assign presented_key = {target, data_word};
	assign key_open = (nv_key == fmsp_pkg::KEY_DEFAULT);
	// Once a key is stored, protection writes need it presented
	assign key_ok = key_open || (presented_key == nv_key);
	assign ew_en = mode[fmsp_pkg::MODE_EW_EN];
	// Kernel group (last four pages) is never writable
	assign page_guarded = (target[fmsp_pkg::GROUP_HI:fmsp_pkg::GROUP_LO] == fmsp_pkg::PROT_KERNEL_GROUP)
		|| !live[target[fmsp_pkg::GROUP_HI:fmsp_pkg::GROUP_LO]];
	assign abort_now = mode[fmsp_pkg::MODE_ABORT_EN] && abort_i;
	assign mass_ok = ew_en && target == fmsp_pkg::MASS_KEY_ADDR && data_word == fmsp_pkg::MASS_KEY_DATA;
	assign sig_start = {target[fmsp_pkg::HALF_HI:fmsp_pkg::HALF_LO], 8'h00};
	assign sig_end = {data_word[fmsp_pkg::HALF_HI:fmsp_pkg::HALF_LO], 8'h00};
	// Same half-page, or an empty range after the tail skip: nothing signed, old signature kept
	assign sig_empty = (target[fmsp_pkg::HALF_HI:fmsp_pkg::HALF_LO] == data_word[fmsp_pkg::HALF_HI:fmsp_pkg::HALF_LO])
		|| sig_end <= sig_start + fmsp_pkg::SIG_TAIL;

	// ====================================================
	// Nonvolatile store and signature generator
	logic nv_save, nv_set_key, nv_erase;
	logic lock_ok;

	// Permanent key refuses any protect-command change of the saved word
	assign lock_ok = ew_en && key_ok && nv_key != fmsp_pkg::KEY_PERMANENT
		&& mode[fmsp_pkg::MODE_LOCK_HI:fmsp_pkg::MODE_LOCK_LO] == fmsp_pkg::LOCK_PATTERN;
	assign nv_save = wr_cmd && bus_wdata_i[7:0] == fmsp_pkg::CMD_PROTECT && lock_ok;
	assign nv_set_key = nv_save && key_open;
	// Mass erase finishing resets key and saved word
	assign nv_erase = state == fmsp_pkg::FMSP_ST_FLASH && fl_ack_i && fl_op_o == fmsp_pkg::FMSP_OP_MASS;

	fmsp_nv_store u_nv (
		.sys_clk_i(sys_clk_i),
		.por_i(por_i),
		.save_i(nv_save),
		.set_key_i(nv_set_key),
		.erase_i(nv_erase),
		.pro_i(persist),
		.key_i(presented_key),
		.pro_o(nv_pro),
		.key_o(nv_key)
	);

	fmsp_sig_gen u_sig (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.sig_bus(sig_bus)
	);

	assign sig_bus.start = wr_cmd && bus_wdata_i[7:0] == fmsp_pkg::CMD_SIGN && !sig_empty;
	assign sig_bus.word_valid = state == fmsp_pkg::FMSP_ST_SIGN && fl_ack_i && !abort_now;
	assign sig_bus.word = fl_rdata_i;

	// ====================================================
	// Software registers
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			mode <= fmsp_pkg::MODE_RST;
		else if (wr_mode)
			mode <= bus_wdata_i[15:0] & fmsp_pkg::MODE_WMASK;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			target <= fmsp_pkg::TARGET_RST;
		else if (wr_target)
			target <= bus_wdata_i[15:0];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			data_word <= fmsp_pkg::DATA_RST;
		else if (wr_data)
			data_word <= bus_wdata_i[15:0];
		else if (state == fmsp_pkg::FMSP_ST_FLASH && fl_ack_i && cur_cmd == fmsp_pkg::CMD_READ)
			data_word <= fl_rdata_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			persist <= fmsp_pkg::PERSIST_RST;
		else if (state == fmsp_pkg::FMSP_ST_LOAD)
			persist <= nv_pro;
		else if (wr_persist)
			persist <= bus_wdata_i;
	end

	// Volatile: written directly, reloaded from the saved word after reset only while a key is stored
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			live <= fmsp_pkg::LIVE_RST;
		else if (state == fmsp_pkg::FMSP_ST_LOAD && !key_open)
			live <= nv_pro;
		else if (wr_live)
			live <= bus_wdata_i;
	end

	// Status flags: a completion in the read cycle survives the clear
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			status <= 4'h0;
		else
		begin
			if (rd_status)
			begin
				status[fmsp_pkg::STA_IRQ] <= 1'b0;
				status[fmsp_pkg::STA_FAIL] <= 1'b0;
				status[fmsp_pkg::STA_OK] <= 1'b0;
			end
			if (done_ok || done_fail)
				status[fmsp_pkg::STA_IRQ] <= mode[fmsp_pkg::MODE_IRQ_EN];
			if (done_ok)
				status[fmsp_pkg::STA_OK] <= 1'b1;
			if (done_fail)
				status[fmsp_pkg::STA_FAIL] <= 1'b1;
			status[fmsp_pkg::STA_BUSY] <= !idle && state != fmsp_pkg::FMSP_ST_DONE;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			cmd <= fmsp_pkg::CMD_IDLE;
		else if (wr_cmd)
			cmd <= bus_wdata_i[7:0];
		else if (state == fmsp_pkg::FMSP_ST_DONE)
			cmd <= fmsp_pkg::CMD_IDLE;
	end

	// ====================================================
	// Command sequencer
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state <= fmsp_pkg::FMSP_ST_LOAD;
			cur_cmd <= fmsp_pkg::CMD_IDLE;
			fl_req_o <= 1'b0;
			fl_op_o <= fmsp_pkg::FMSP_OP_READ;
			fl_addr_o <= 16'h0000;
			fl_wdata_o <= 16'h0000;
			walk <= 16'h0000;
			sig_limit <= 16'h0000;
			pend_prog <= 1'b0;
			done_ok <= 1'b0;
			done_fail <= 1'b0;
		end
		else
		begin
			done_ok <= 1'b0;
			done_fail <= 1'b0;
			case (state)
				fmsp_pkg::FMSP_ST_LOAD:
					state <= fmsp_pkg::FMSP_ST_IDLE;
				fmsp_pkg::FMSP_ST_IDLE:
					if (wr_cmd)
					begin
						cur_cmd <= bus_wdata_i[7:0];
						fl_addr_o <= target;
						fl_wdata_o <= data_word;
						pend_prog <= 1'b0;
						state <= fmsp_pkg::FMSP_ST_DONE;
						case (bus_wdata_i[7:0])
							fmsp_pkg::CMD_READ, fmsp_pkg::CMD_VERIFY:
							begin
								fl_req_o <= 1'b1;
								fl_op_o <= fmsp_pkg::FMSP_OP_READ;
								state <= fmsp_pkg::FMSP_ST_FLASH;
							end
							fmsp_pkg::CMD_WRITE, fmsp_pkg::CMD_ERASE_WRITE, fmsp_pkg::CMD_ERASE:
								if (!ew_en || page_guarded)
									done_fail <= 1'b1;
								else
								begin
									fl_req_o <= 1'b1;
									fl_op_o <= (bus_wdata_i[7:0] == fmsp_pkg::CMD_WRITE) ?
										fmsp_pkg::FMSP_OP_PROG : fmsp_pkg::FMSP_OP_ERASE;
									pend_prog <= bus_wdata_i[7:0] == fmsp_pkg::CMD_ERASE_WRITE;
									state <= fmsp_pkg::FMSP_ST_FLASH;
								end
							fmsp_pkg::CMD_MASS:
								if (!mass_ok)
									done_fail <= 1'b1;
								else
								begin
									fl_req_o <= 1'b1;
									fl_op_o <= fmsp_pkg::FMSP_OP_MASS;
									state <= fmsp_pkg::FMSP_ST_FLASH;
								end
							fmsp_pkg::CMD_SIGN:
								if (sig_empty)
									done_ok <= 1'b1;
								else
								begin
									walk <= sig_start;
									sig_limit <= sig_end - fmsp_pkg::SIG_TAIL;
									fl_req_o <= 1'b1;
									fl_op_o <= fmsp_pkg::FMSP_OP_READ;
									fl_addr_o <= sig_start;
									state <= fmsp_pkg::FMSP_ST_SIGN;
								end
							fmsp_pkg::CMD_PROTECT:
								if (lock_ok)
									done_ok <= 1'b1;
								else
									done_fail <= 1'b1;
							fmsp_pkg::CMD_PING:
								done_ok <= 1'b1;
							default:
								done_fail <= 1'b1;
						endcase
					end
				fmsp_pkg::FMSP_ST_FLASH:
					if (abort_now)
					begin
						fl_req_o <= 1'b0;
						done_fail <= 1'b1;
						state <= fmsp_pkg::FMSP_ST_DONE;
					end
					else if (fl_ack_i && pend_prog)
					begin
						// Erase half of erase-write done: program the word next
						pend_prog <= 1'b0;
						fl_op_o <= fmsp_pkg::FMSP_OP_PROG;
					end
					else if (fl_ack_i)
					begin
						fl_req_o <= 1'b0;
						if (cur_cmd == fmsp_pkg::CMD_VERIFY && fl_rdata_i != data_word)
							done_fail <= 1'b1;
						else
							done_ok <= 1'b1;
						state <= fmsp_pkg::FMSP_ST_DONE;
					end
				fmsp_pkg::FMSP_ST_SIGN:
					if (abort_now)
					begin
						fl_req_o <= 1'b0;
						done_fail <= 1'b1;
						state <= fmsp_pkg::FMSP_ST_DONE;
					end
					else if (fl_ack_i)
					begin
						walk <= walk + fmsp_pkg::WORD_STEP;
						fl_addr_o <= walk + fmsp_pkg::WORD_STEP;
						if (walk + fmsp_pkg::WORD_STEP >= sig_limit)
						begin
							fl_req_o <= 1'b0;
							done_ok <= 1'b1;
							state <= fmsp_pkg::FMSP_ST_DONE;
						end
					end
				fmsp_pkg::FMSP_ST_DONE:
					state <= fmsp_pkg::FMSP_ST_IDLE;
				default:
					state <= fmsp_pkg::FMSP_ST_IDLE;
			endcase
		end
	end

	// ====================================================
	// Read path and side outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			bus_rdata_o <= 32'h00000000;
		else if (bus_rd_i)
			case (bus_addr_i)
				fmsp_pkg::ADDR_STATUS: bus_rdata_o <= {28'h0000000, status};
				fmsp_pkg::ADDR_MODE: bus_rdata_o <= {16'h0000, mode};
				fmsp_pkg::ADDR_CMD: bus_rdata_o <= {24'h000000, cmd};
				fmsp_pkg::ADDR_DATA: bus_rdata_o <= {16'h0000, data_word};
				fmsp_pkg::ADDR_TARGET: bus_rdata_o <= {16'h0000, target};
				fmsp_pkg::ADDR_SIG: bus_rdata_o <= {8'h00, sig_bus.sig};
				fmsp_pkg::ADDR_PERSIST: bus_rdata_o <= persist;
				fmsp_pkg::ADDR_LIVE: bus_rdata_o <= live;
				default: bus_rdata_o <= 32'h00000000;
			endcase
	end

	assign dbg_rd_grant_o = dbg_rd_req_i && live[fmsp_pkg::PROT_READ_BIT];
	assign irq_o = status[fmsp_pkg::STA_IRQ];
endmodule
`default_nettype wire

/* File: fmsp_pkg.sv */
// Shared constants and types of the flash mode, signature and protection block
package fmsp_pkg;
	// ====================================================
	// Register byte addresses
	localparam logic [31:0] ADDR_STATUS = 32'hFFFF0E00;
	localparam logic [31:0] ADDR_MODE = 32'hFFFF0E04;
	localparam logic [31:0] ADDR_CMD = 32'hFFFF0E08;
	localparam logic [31:0] ADDR_DATA = 32'hFFFF0E0C;
	localparam logic [31:0] ADDR_TARGET = 32'hFFFF0E10;
	localparam logic [31:0] ADDR_SIG = 32'hFFFF0E18;
	localparam logic [31:0] ADDR_PERSIST = 32'hFFFF0E1C;
	localparam logic [31:0] ADDR_LIVE = 32'hFFFF0E20;
	// ====================================================
	// Reset values and keys
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] TARGET_RST = 16'h0000;
	localparam logic [23:0] SIG_RST = 24'h000000;
	localparam logic [31:0] PERSIST_RST = 32'h00000000;
	localparam logic [31:0] LIVE_RST = 32'h0FFFFFFF;
	localparam logic [31:0] KEY_DEFAULT = 32'hFFFFFFFF;
	localparam logic [31:0] KEY_PERMANENT = 32'hDEADDEAD;
	localparam logic [15:0] MASS_KEY_ADDR = 16'hFFC3;
	localparam logic [15:0] MASS_KEY_DATA = 16'h3CFF;
	// ====================================================
	// Mode register fields
	localparam int MODE_LOCK_HI = 6;
	localparam int MODE_LOCK_LO = 5;
	localparam int MODE_IRQ_EN = 4;
	localparam int MODE_EW_EN = 3;
	localparam int MODE_ABORT_EN = 1;
	localparam logic [1:0] LOCK_PATTERN = 2'h2;
	localparam logic [15:0] MODE_WMASK = 16'h007A;
	// ====================================================
	// Status register fields
	localparam int STA_IRQ = 3;
	localparam int STA_BUSY = 2;
	localparam int STA_FAIL = 1;
	localparam int STA_OK = 0;
	// ====================================================
	// Protection layout
	localparam int PROT_READ_BIT = 31;
	localparam logic [4:0] PROT_KERNEL_GROUP = 5'h1F;
	localparam int GROUP_HI = 15;
	localparam int GROUP_LO = 11;
	localparam int HALF_HI = 15;
	localparam int HALF_LO = 8;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] SIG_TAIL = 16'h0004;
	localparam logic [23:0] SIG_SEED = 24'hFFFFFF;
	localparam logic [23:0] SIG_TAPS = 24'hE10000;
	// ====================================================
	// Commands
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
	localparam logic [7:0] CMD_VERIFY = 8'h04;
	localparam logic [7:0] CMD_ERASE = 8'h05;
	localparam logic [7:0] CMD_MASS = 8'h06;
	localparam logic [7:0] CMD_IDLE = 8'h07;
	localparam logic [7:0] CMD_SIGN = 8'h0B;
	localparam logic [7:0] CMD_PROTECT = 8'h0C;
	localparam logic [7:0] CMD_PING = 8'h0F;
	// ====================================================
	// Types
	typedef enum logic [1:0] {
		FMSP_OP_READ = 2'h0,
		FMSP_OP_PROG = 2'h1,
		FMSP_OP_ERASE = 2'h2,
		FMSP_OP_MASS = 2'h3
	} fmsp_op_t;
	typedef enum logic [2:0] {
		FMSP_ST_LOAD = 3'h0,
		FMSP_ST_IDLE = 3'h1,
		FMSP_ST_FLASH = 3'h2,
		FMSP_ST_SIGN = 3'h3,
		FMSP_ST_DONE = 3'h4
	} fmsp_state_t;
endpackage

/* File: fmsp_sig_if.sv */
// Link between the controller and the signature generator
`timescale 1ns/1ps
`default_nettype none
interface fmsp_sig_if;
	logic start;
	logic word_valid;
	logic [15:0] word;
	logic [23:0] sig;
	modport ctrl (output start, output word_valid, output word, input sig);
	modport gen (input start, input word_valid, input word, output sig);
endinterface
`default_nettype wire

/* File: fmsp_sig_gen.sv */
// Signature generator: 24-bit LFSR folding in each flash word
`timescale 1ns/1ps
`default_nettype none
module fmsp_sig_gen (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	fmsp_sig_if.gen sig_bus
);
	logic [23:0] lfsr;
	logic feedback;

	assign feedback = ^(lfsr & fmsp_pkg::SIG_TAPS);
	assign sig_bus.sig = lfsr;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			lfsr <= fmsp_pkg::SIG_RST;
		else if (sig_bus.start)
			lfsr <= fmsp_pkg::SIG_SEED;
		else if (sig_bus.word_valid)
			lfsr <= {lfsr[22:0], feedback} ^ {8'h00, sig_bus.word};
	end
endmodule
`default_nettype wire

/* File: fmsp_nv_store.sv */
// Nonvolatile protection word and key; survives system reset, cleared by power-on or mass erase
`timescale 1ns/1ps
`default_nettype none
module fmsp_nv_store (
	input wire logic sys_clk_i,
	input wire logic por_i,
	input wire logic save_i,
	input wire logic set_key_i,
	input wire logic erase_i,
	input wire logic [31:0] pro_i,
	input wire logic [31:0] key_i,
	output logic [31:0] pro_o,
	output logic [31:0] key_o
);
	// System reset deliberately does not touch these: they model flash-held state
	always_ff @(posedge sys_clk_i)
	begin
		if (por_i || erase_i)
			pro_o <= fmsp_pkg::PERSIST_RST;
		else if (save_i)
			pro_o <= pro_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (por_i || erase_i)
			key_o <= fmsp_pkg::KEY_DEFAULT;
		else if (set_key_i)
			key_o <= key_i;
	end
endmodule
`default_nettype wire

/* File: fmsp_ctrl_asserts.sv */
// Port-level checker of the flash mode, signature and protection controller
`timescale 1ns/1ps
`default_nettype none
module fmsp_ctrl_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic [31:0] bus_addr_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic [31:0] bus_rdata_o,
	input wire logic fl_req_o,
	input wire fmsp_pkg::fmsp_op_t fl_op_o,
	input wire logic [15:0] fl_addr_o,
	input wire logic [15:0] fl_wdata_o,
	input wire logic fl_ack_i,
	input wire logic [15:0] fl_rdata_i,
	input wire logic abort_i,
	input wire logic dbg_rd_req_i,
	input wire logic dbg_rd_grant_o,
	input wire logic irq_o
);
	// ====
	// Shadow of the mode register, rebuilt from bus writes
	logic [15:0] mode_q;
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			mode_q <= 16'h0000;
		else if (bus_wr_i && bus_addr_i == fmsp_pkg::ADDR_MODE)
			mode_q <= bus_wdata_i[15:0];
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	// ====
	// Properties
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !fl_req_o && !irq_o && bus_rdata_o == 32'h00000000)
		else $error("outputs not quiet after reset");
	mode_rsvd_a: assert property (bus_rd_i && bus_addr_i == fmsp_pkg::ADDR_MODE |=> bus_rdata_o == 32'(mode_q & fmsp_pkg::MODE_WMASK))
		else $error("mode readback wrong");
	req_hold_a: assert property (fl_req_o && !fl_ack_i && !abort_i |=> fl_req_o && $stable(fl_addr_o) && $stable(fl_op_o)
		&& $stable(fl_wdata_o))
		else $error("flash request changed before answer");
	prog_drop_a: assert property (fl_req_o && fl_ack_i && fl_op_o == fmsp_pkg::FMSP_OP_PROG |=> !fl_req_o)
		else $error("program request not dropped after ack");
	ew_gate_a: assert property (fl_req_o && !mode_q[fmsp_pkg::MODE_EW_EN] |-> fl_op_o == fmsp_pkg::FMSP_OP_READ)
		else $error("erase or program with write enable clear");
	irq_gate_a: assert property ($rose(irq_o) |-> mode_q[fmsp_pkg::MODE_IRQ_EN])
		else $error("interrupt while disabled");
	abort_drop_a: assert property (abort_i && fl_req_o && !fl_ack_i && mode_q[fmsp_pkg::MODE_ABORT_EN] |=> !fl_req_o)
		else $error("abort did not cancel request");
	dbg_grant_a: assert property (dbg_rd_grant_o |-> dbg_rd_req_i)
		else $error("debug grant without request");
endmodule
bind fmsp_ctrl fmsp_ctrl_asserts chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i), .bus_addr_i(bus_addr_i),
	.bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
	.fl_req_o(fl_req_o), .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o), .fl_ack_i(fl_ack_i),
	.fl_rdata_i(fl_rdata_i), .abort_i(abort_i), .dbg_rd_req_i(dbg_rd_req_i), .dbg_rd_grant_o(dbg_rd_grant_o),
	.irq_o(irq_o));
`default_nettype wire

/* File: fmsp_flash_model.sv */
// Behavioural flash array answering the controller's request link
`timescale 1ns/1ps
`default_nettype none
module fmsp_flash_model (
	input wire logic sys_clk_i,
	input wire logic stall_i,
	input wire logic fl_req_i,
	input wire fmsp_pkg::fmsp_op_t fl_op_i,
	input wire logic [15:0] fl_addr_i,
	input wire logic [15:0] fl_wdata_i,
	output logic fl_ack_o,
	output logic [15:0] fl_rdata_o
);
	// ====
	// Unwritten words are absent and read as all ones; erased words are stored as all ones
	logic [15:0] mem [int];
	int wait_n = 0;
	int n_rd = 0;
	int k;
	initial
	begin
		fl_ack_o = 1'b0;
		fl_rdata_o = 16'h0000;
	end
	always @(posedge sys_clk_i)
	begin
		#1;
		// Read data outside the ack cycle is garbage on purpose
		fl_rdata_o = ~fl_rdata_o;
		if (fl_ack_o || !fl_req_i || stall_i)
			fl_ack_o = 1'b0;
		else if (wait_n > 0)
			wait_n--;
		else
		begin
			wait_n = $urandom_range(0, 3);
			fl_ack_o = 1'b1;
			case (fl_op_i)
				fmsp_pkg::FMSP_OP_READ:
				begin
					fl_rdata_o = mem.exists({17'h00000, fl_addr_i[15:1]}) ? mem[{17'h00000, fl_addr_i[15:1]}] : 16'hFFFF;
					n_rd++;
				end
				fmsp_pkg::FMSP_OP_PROG: mem[{17'h00000, fl_addr_i[15:1]}] = fl_wdata_i;
				fmsp_pkg::FMSP_OP_ERASE:
					for (k = 0; k < 256; k++)
						mem[{17'h00000, fl_addr_i[15:9], k[7:0]}] = 16'hFFFF;
				default:
					foreach (mem[j])
						if (j < 32'h00007C00)
							mem[j] = 16'hFFFF;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: tb_flash_mode_signature_protection.sv */
// Self-checking bench of the flash mode, signature and protection controller
`timescale 1ns/1ps
`default_nettype none
module tb_flash_mode_signature_protection;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	logic [31:0] bus_addr_i = 32'h00000000;
	logic bus_wr_i = 1'b0;
	logic bus_rd_i = 1'b0;
	logic [31:0] bus_wdata_i = 32'h00000000;
	logic abort_i = 1'b0;
	logic dbg_rd_req_i = 1'b1;
	logic stall = 1'b0;
	logic [31:0] bus_rdata_o;
	logic fl_req_o;
	fmsp_pkg::fmsp_op_t fl_op_o;
	logic [15:0] fl_addr_o;
	logic [15:0] fl_wdata_o;
	logic fl_ack_i;
	logic [15:0] fl_rdata_i;
	logic dbg_rd_grant_o;
	logic irq_o;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [31:0] ra [5] = '{fmsp_pkg::ADDR_MODE, fmsp_pkg::ADDR_DATA, fmsp_pkg::ADDR_PERSIST, fmsp_pkg::ADDR_LIVE, 32'hFFFF0E14};
	logic [31:0] rv [5] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h0FFFFFFF, 32'h00000000};
	always #5 sys_clk_i = ~sys_clk_i;
	fmsp_ctrl dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
		.bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .fl_req_o(fl_req_o),
		.fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o), .fl_ack_i(fl_ack_i),
		.fl_rdata_i(fl_rdata_i), .abort_i(abort_i), .dbg_rd_req_i(dbg_rd_req_i), .dbg_rd_grant_o(dbg_rd_grant_o),
		.irq_o(irq_o));
	fmsp_flash_model flash_u (.sys_clk_i(sys_clk_i), .stall_i(stall), .fl_req_i(fl_req_o), .fl_op_i(fl_op_o),
		.fl_addr_i(fl_addr_o), .fl_wdata_i(fl_wdata_o), .fl_ack_o(fl_ack_i), .fl_rdata_o(fl_rdata_i));
	// ====
	// Bus and command tasks
	task automatic stop_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic do_reset(input logic p);
		@(posedge sys_clk_i) #1;
		rst_i = 1'b1;
		por_i = p;
		repeat (2) @(posedge sys_clk_i);
		#1;
		rst_i = 1'b0;
		por_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk_i) #1;
		bus_addr_i = a;
		bus_wdata_i = d;
		bus_wr_i = 1'b1;
		@(posedge sys_clk_i) #1;
		bus_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge sys_clk_i) #1;
		bus_addr_i = a;
		bus_rd_i = 1'b1;
		@(posedge sys_clk_i) #1;
		bus_rd_i = 1'b0;
		d = bus_rdata_o;
	endtask
	// Status flags clear on read, so every poll is folded into the result
	task automatic cmd(input logic [7:0] c, input logic ab, output logic [31:0] s);
		logic [31:0] v;
		s = 32'h00000000;
		wr(fmsp_pkg::ADDR_CMD, {24'h000000, c});
		abort_i = ab;
		for (int i = 0; i < 3000; i++)
		begin
			rd(fmsp_pkg::ADDR_STATUS, v);
			s = s | v;
			if (!v[fmsp_pkg::STA_BUSY] && s[1:0] != 2'h0)
				break;
		end
		abort_i = 1'b0;
		s = s & 32'h0000000B;
	endtask
	task automatic prog(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c, input logic ab,
		output logic [31:0] s);
		wr(fmsp_pkg::ADDR_TARGET, {16'h0000, a});
		wr(fmsp_pkg::ADDR_DATA, {16'h0000, d});
		cmd(c, ab, s);
	endtask
	task automatic rdw(input logic [15:0] a, output logic [31:0] v);
		prog(a, 16'h0000, fmsp_pkg::CMD_READ, 1'b0, v);
		rd(fmsp_pkg::ADDR_DATA, v);
	endtask
	task automatic lock(input logic [31:0] k, input logic [31:0] md, output logic [31:0] s);
		wr(fmsp_pkg::ADDR_PERSIST, 32'hFFFFFFFB);
		wr(fmsp_pkg::ADDR_MODE, md);
		prog(k[31:16], k[15:0], fmsp_pkg::CMD_PROTECT, 1'b0, s);
	endtask
	task automatic mass(output logic [31:0] s);
		wr(fmsp_pkg::ADDR_MODE, 32'h00000008);
		prog(16'hFFC3, 16'h3CFF, fmsp_pkg::CMD_MASS, 1'b0, s);
	endtask
	// ====
	// Scenarios
	initial
	begin
		logic [31:0] v;
		logic [31:0] s;
		logic [31:0] sg;
		logic [31:0] key;
		logic [15:0] a;
		logic [15:0] d;
		logic m;
		int n;
		void'($urandom(157));
		do_reset(1'b1);
		foreach (ra[i])
		begin
			rd(ra[i], v);
			chk("reset value", v, rv[i]);
		end
		chk("debug grant", 32'(dbg_rd_grant_o), 32'h00000000);
		wr(fmsp_pkg::ADDR_MODE, 32'h0000007F);
		rd(fmsp_pkg::ADDR_MODE, v);
		chk("mode bits", v, 32'h0000007A);
		wr(fmsp_pkg::ADDR_MODE, 32'h00000000);
		prog(16'h0010, 16'h1234, fmsp_pkg::CMD_WRITE, 1'b0, s);
		chk("gated write", s, 32'h00000002);
		rdw(16'h0010, v);
		chk("gated word", v, 32'h0000FFFF);
		for (n = 0; n < 4; n++)
		begin
			a = 16'($urandom_range(0, 32'h0000DFFF)) & 16'hFFFE;
			d = 16'($urandom);
			m = 1'($urandom_range(0, 1));
			wr(fmsp_pkg::ADDR_MODE, m ? 32'h00000018 : 32'h00000008);
			prog(a, d, fmsp_pkg::CMD_ERASE_WRITE, 1'b0, s);
			chk("program status", s, {28'h0000000, m, 3'h1});
			rdw(a, v);
			chk("word", v, {16'h0000, d});
		end
		prog(a, d, fmsp_pkg::CMD_VERIFY, 1'b0, s);
		chk("verify match", s, {28'h0000000, m, 3'h1});
		prog(a, ~d, fmsp_pkg::CMD_VERIFY, 1'b0, s);
		chk("verify mismatch", s, {28'h0000000, m, 3'h2});
		wr(fmsp_pkg::ADDR_CMD, {24'h000000, fmsp_pkg::CMD_PING});
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk("irq line", 32'(irq_o), 32'(m));
		rd(fmsp_pkg::ADDR_STATUS, v);
		chk("ping status", v, {28'h0000000, m, 3'h1});
		prog(a, d, fmsp_pkg::CMD_ERASE, 1'b0, s);
		rdw(a, v);
		chk("erased word", v, 32'h0000FFFF);
		n = $urandom_range(0, 27);
		a = 16'(n * 2048 + 64);
		wr(fmsp_pkg::ADDR_LIVE, ~(32'h00000001 << n));
		prog(a, d, fmsp_pkg::CMD_WRITE, 1'b0, s);
		chk("protected write", s, 32'h00000002);
		chk("debug grant", 32'(dbg_rd_grant_o), 32'h00000001);
		dbg_rd_req_i = 1'b0;
		#1;
		chk("debug grant idle", 32'(dbg_rd_grant_o), 32'h00000000);
		wr(fmsp_pkg::ADDR_LIVE, 32'hFFFFFFFF);
		prog(a, d, fmsp_pkg::CMD_WRITE, 1'b0, s);
		chk("released write", s, 32'h00000001);
		n = flash_u.n_rd;
		prog(16'h0100, 16'h0300, fmsp_pkg::CMD_SIGN, 1'b0, s);
		chk("sign status", s, 32'h00000001);
		chk("words signed", 32'(flash_u.n_rd - n), 32'h000000FE);
		rd(fmsp_pkg::ADDR_SIG, sg);
		wr(fmsp_pkg::ADDR_SIG, ~sg);
		n = flash_u.n_rd;
		prog(16'h0100, 16'h01F0, fmsp_pkg::CMD_SIGN, 1'b0, s);
		chk("same page reads", 32'(flash_u.n_rd - n), 32'h00000000);
		rd(fmsp_pkg::ADDR_SIG, v);
		chk("signature kept", v, sg);
		// Page zero's signature word sits in the skipped tail, so storing it must not change the result
		prog(16'h0000, 16'h0200, fmsp_pkg::CMD_SIGN, 1'b0, s);
		rd(fmsp_pkg::ADDR_SIG, sg);
		prog(16'h01FC, sg[15:0], fmsp_pkg::CMD_WRITE, 1'b0, s);
		prog(16'h0000, 16'h0200, fmsp_pkg::CMD_SIGN, 1'b0, s);
		rd(fmsp_pkg::ADDR_SIG, v);
		chk("page zero signature", v, sg);
		wr(fmsp_pkg::ADDR_MODE, 32'h0000000A);
		stall = 1'b1;
		prog(16'h0200, d, fmsp_pkg::CMD_WRITE, 1'b1, s);
		stall = 1'b0;
		chk("aborted write", s, 32'h00000002);
		wr(fmsp_pkg::ADDR_MODE, 32'h00000008);
		prog(16'h0200, d, fmsp_pkg::CMD_WRITE, 1'b1, s);
		chk("abort ignored", s, 32'h00000001);
		key = $urandom & 32'h7FFFFFFE;
		lock(key, 32'h00000008, s);
		chk("lock bad mode", s, 32'h00000002);
		lock(key, 32'h00000048, s);
		chk("lock", s, 32'h00000001);
		do_reset(1'b0);
		wr(fmsp_pkg::ADDR_LIVE, 32'hFFFFFFFF);
		rd(fmsp_pkg::ADDR_LIVE, v);
		chk("reloaded live", v, 32'hFFFFFFFB);
		lock(fmsp_pkg::KEY_PERMANENT, 32'h00000048, s);
		chk("relock other key", s, 32'h00000002);
		mass(s);
		chk("mass erase", s, 32'h00000001);
		rdw(a, v);
		chk("mass erased word", v, 32'h0000FFFF);
		lock(fmsp_pkg::KEY_PERMANENT, 32'h00000048, s);
		chk("permanent lock", s, 32'h00000001);
		lock(fmsp_pkg::KEY_PERMANENT, 32'h00000048, s);
		chk("permanent relock", s, 32'h00000002);
		mass(s);
		chk("mass after permanent", s, 32'h00000001);
		do_reset(1'b0);
		rd(fmsp_pkg::ADDR_LIVE, v);
		chk("default live", v, 32'h0FFFFFFF);
		stop_test();
	end
	// Run needs well under 20k cycles; this is a generous ceiling
	initial
	begin
		#500000;
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
